//--- common/jtag_tap_consts.vh
`ifndef JTAG_TAP_CONSTS_VH
`define JTAG_TAP_CONSTS_VH

// ==========================================================
// instruction register
`define IR_LEN 4
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_STREAM 4'h4
`define IR_BYPASS 4'hf
// fixed pattern loaded in capture-ir, low two bits 01
`define IR_CAPTURE 4'h1

// ==========================================================
// data register sizes
`define BSR_NIN 4
`define BSR_NOUT 4
`define STREAM_LEN 8
`define FIFO_DEPTH 8
`define FIFO_AW 3

// ==========================================================
// test clock periods of tms high that always reach reset
`define TMS_RESET_CLOCKS 5

`endif

//--- rtl/scan_fifo.v
`include "jtag_tap_consts.vh"

// ==========================================================
// fifo with a registered output stage
module scan_fifo #(
   parameter WIDTH = `STREAM_LEN,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW = `FIFO_AW
) (
   input wire clk_in,
   input wire resetn_in,
   input wire ce_in,
   input wire wr_valid_in,
   input wire [WIDTH-1:0] wr_data_in,
   output wire wr_ready_out,
   output reg rd_valid_out,
   output reg [WIDTH-1:0] rd_data_out,
   input wire rd_ready_in
);

   localparam [AW:0] FULL = DEPTH[AW:0];

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp;
   reg [AW-1:0] rp;
   reg [AW:0] cnt;
   wire push;
   wire pop;

   // full when every memory word is taken
   assign wr_ready_out = (cnt != FULL);
   assign push = wr_valid_in & wr_ready_out;
   assign pop = (cnt != {(AW+1){1'b0}}) & (~rd_valid_out | rd_ready_in);

   // memory array, no reset needed
   always @(posedge clk_in) begin
      if (ce_in && push) begin
         mem[wp] <= wr_data_in;
      end
   end

   // pointers, count and output register
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wp <= {AW{1'b0}};
         rp <= {AW{1'b0}};
         cnt <= {(AW+1){1'b0}};
         rd_valid_out <= 1'b0;
         rd_data_out <= {WIDTH{1'b0}};
      end else if (ce_in) begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
            rd_data_out <= mem[rp];
            rd_valid_out <= 1'b1;
         end else if (rd_ready_in) begin
            rd_valid_out <= 1'b0;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end

endmodule // scan_fifo

//--- rtl/jtag_tap_controller.v
`include "jtag_tap_consts.vh"

module jtag_tap_controller #(
   parameter NIN = `BSR_NIN,
   parameter NOUT = `BSR_NOUT,
   parameter SW = `STREAM_LEN,
   parameter FDEPTH = `FIFO_DEPTH,
   parameter FAW = `FIFO_AW
) (
   input wire mclk_in,
   input wire resetn_in,
   input wire ce_in,
   input wire tck_in,
   input wire tms_in,
   input wire tdi_in,
   input wire trst_n_in,
   output reg tdo_out,
   output reg tdo_oe_out,
   input wire [NIN-1:0] pad_in,
   output reg [NIN-1:0] core_in_out,
   input wire [NOUT-1:0] core_out_in,
   output reg [NOUT-1:0] pad_out,
   output reg test_mode_out,
   output wire [SW-1:0] stream_data_out,
   output wire stream_valid_out,
   input wire stream_ready_in
);

   localparam NB = NIN + NOUT;

   // ==========================================================
   // tap states
   localparam [3:0] S_RESET = 4'h0;
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SEL_DR = 4'h2;
   localparam [3:0] S_CAP_DR = 4'h3;
   localparam [3:0] S_SH_DR = 4'h4;
   localparam [3:0] S_EX1_DR = 4'h5;
   localparam [3:0] S_PA_DR = 4'h6;
   localparam [3:0] S_EX2_DR = 4'h7;
   localparam [3:0] S_UPD_DR = 4'h8;
   localparam [3:0] S_SEL_IR = 4'h9;
   localparam [3:0] S_CAP_IR = 4'ha;
   localparam [3:0] S_SH_IR = 4'hb;
   localparam [3:0] S_EX1_IR = 4'hc;
   localparam [3:0] S_PA_IR = 4'hd;
   localparam [3:0] S_EX2_IR = 4'he;
   localparam [3:0] S_UPD_IR = 4'hf;

   // ==========================================================
   // next state of the sixteen-state graph
   function [3:0] tap_next;
      input [3:0] st;
      input tms;
      begin
         case (st)
            S_RESET: tap_next = tms ? S_RESET : S_IDLE;
            S_IDLE: tap_next = tms ? S_SEL_DR : S_IDLE;
            S_SEL_DR: tap_next = tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: tap_next = tms ? S_EX1_DR : S_SH_DR;
            S_SH_DR: tap_next = tms ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: tap_next = tms ? S_UPD_DR : S_PA_DR;
            S_PA_DR: tap_next = tms ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: tap_next = tms ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: tap_next = tms ? S_SEL_DR : S_IDLE;
            S_SEL_IR: tap_next = tms ? S_RESET : S_CAP_IR;
            S_CAP_IR: tap_next = tms ? S_EX1_IR : S_SH_IR;
            S_SH_IR: tap_next = tms ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: tap_next = tms ? S_UPD_IR : S_PA_IR;
            S_PA_IR: tap_next = tms ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: tap_next = tms ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: tap_next = tms ? S_SEL_DR : S_IDLE;
            default: tap_next = S_RESET;
         endcase
      end
   endfunction

   // boundary register owns the path for extest and sample
   function uses_bsr;
      input [`IR_LEN-1:0] op;
      begin
         uses_bsr = (op == `IR_EXTEST) || (op == `IR_SAMPLE);
      end
   endfunction

   // ==========================================================
   // input synchronisers
   reg [2:0] link_s1;
   reg [2:0] link_s2;
   reg tck_d;
   reg [NIN-1:0] pad_s1;
   reg [NIN-1:0] pad_s2;
   reg [1:0] trst_q;
   wire tap_rst_n;
   wire pin_rst_n;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire tck_rise;
   wire tck_fall;

   assign tck_s = link_s2[0];
   assign tms_s = link_s2[1];
   assign tdi_s = link_s2[2];
   assign tck_rise = ce_in & tck_s & ~tck_d;
   assign tck_fall = ce_in & ~tck_s & tck_d;

   // two flops for link pins and pads, then a test clock edge finder
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link_s1 <= 3'h0;
         link_s2 <= 3'h0;
         tck_d <= 1'b0;
         pad_s1 <= {NIN{1'b0}};
         pad_s2 <= {NIN{1'b0}};
      end else if (ce_in) begin
         link_s1 <= {tdi_in, tms_in, tck_in};
         link_s2 <= link_s1;
         tck_d <= tck_s;
         pad_s1 <= pad_in;
         pad_s2 <= pad_s1;
      end
   end

   // test reset pin asserts at once, releases through two flops
   assign pin_rst_n = resetn_in & trst_n_in;
   always @(posedge mclk_in or negedge pin_rst_n) begin
      if (!pin_rst_n) begin
         trst_q <= 2'h0;
      end else if (ce_in) begin
         trst_q <= {trst_q[0], 1'b1};
      end
   end
   assign tap_rst_n = trst_q[1];

   // ==========================================================
   // tap state and scan registers
   reg [3:0] state;
   reg [`IR_LEN-1:0] ir_sr;
   reg [`IR_LEN-1:0] ir;
   reg bypass;
   reg [NB-1:0] bsr;
   reg [NB-1:0] bsr_latch;
   reg [SW-1:0] stream_sr;
   reg [SW-1:0] pend_data;
   reg pending;
   wire fifo_ready;
   wire push;
   wire sel_bsr;
   wire sel_stream;
   wire [3:0] next_state;

   assign sel_bsr = uses_bsr(ir);
   assign sel_stream = (ir == `IR_STREAM);
   assign next_state = tap_next(state, tms_s);
   assign push = pending & fifo_ready;

   // state machine, stepped only at test clock rises
   always @(posedge mclk_in or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         state <= S_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // instruction shifter and active instruction
   always @(posedge mclk_in or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         ir_sr <= `IR_CAPTURE;
         ir <= `IR_BYPASS;
      end else if (tck_rise) begin
         case (state)
            S_RESET, S_SEL_IR: begin
               if (next_state == S_RESET) begin
                  ir <= `IR_BYPASS;
               end
            end
            S_CAP_IR: begin
               ir_sr <= `IR_CAPTURE;
            end
            S_SH_IR: begin
               ir_sr <= {tdi_s, ir_sr[`IR_LEN-1:1]};
            end
            S_UPD_IR: begin
               ir <= ir_sr;
            end
            default: begin
               ir_sr <= ir_sr;
            end
         endcase
      end
   end

   // data registers: capture, shift, hold and update
   always @(posedge mclk_in or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         bypass <= 1'b0;
         bsr <= {NB{1'b0}};
         bsr_latch <= {NB{1'b0}};
         stream_sr <= {SW{1'b0}};
      end else if (tck_rise) begin
         case (state)
            S_CAP_DR: begin
               bypass <= 1'b0;
               if (sel_bsr) begin
                  bsr <= {core_out_in, pad_s2};
               end
               if (sel_stream) begin
                  stream_sr <= {{(SW-1){1'b0}}, pending};
               end
            end
            S_SH_DR: begin
               if (sel_bsr) begin
                  bsr <= {tdi_s, bsr[NB-1:1]};
               end else if (sel_stream) begin
                  stream_sr <= {tdi_s, stream_sr[SW-1:1]};
               end else begin
                  bypass <= tdi_s;
               end
            end
            S_UPD_DR: begin
               if (sel_bsr) begin
                  bsr_latch <= bsr;
               end
            end
            default: begin
               bsr <= bsr;
            end
         endcase
      end
   end

   // ==========================================================
   // stream register words wait here until the fifo takes them; one updated while a word waits and the fifo is full is dropped
   always @(posedge mclk_in or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         pending <= 1'b0;
         pend_data <= {SW{1'b0}};
      end else if (ce_in) begin
         if (tck_rise && state == S_UPD_DR && sel_stream && (!pending || push)) begin
            pending <= 1'b1;
            pend_data <= stream_sr;
         end else if (push) begin
            pending <= 1'b0;
         end
      end
   end

   scan_fifo #(
      .WIDTH(SW),
      .DEPTH(FDEPTH),
      .AW(FAW)
   ) scan_fifo_i (
      .clk_in(mclk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .wr_valid_in(pending),
      .wr_data_in(pend_data),
      .wr_ready_out(fifo_ready),
      .rd_valid_out(stream_valid_out),
      .rd_data_out(stream_data_out),
      .rd_ready_in(stream_ready_in)
   );

   // ==========================================================
   // serial output, changed on test clock falls
   always @(posedge mclk_in or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_out <= (state == S_SH_DR) || (state == S_SH_IR);
         if (state == S_SH_IR) begin
            tdo_out <= ir_sr[0];
         end else if (sel_bsr) begin
            tdo_out <= bsr[0];
         end else if (sel_stream) begin
            tdo_out <= stream_sr[0];
         end else begin
            tdo_out <= bypass;
         end
      end
   end

   // pads follow the core unless extest drives them from the latch
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         test_mode_out <= 1'b0;
         pad_out <= {NOUT{1'b0}};
         core_in_out <= {NIN{1'b0}};
      end else if (ce_in) begin
         test_mode_out <= (ir == `IR_EXTEST);
         if (ir == `IR_EXTEST) begin
            pad_out <= bsr_latch[NB-1:NIN];
            core_in_out <= bsr_latch[NIN-1:0];
         end else begin
            pad_out <= core_out_in;
            core_in_out <= pad_s2;
         end
      end
   end

endmodule // jtag_tap_controller

//--- tb/jtag_tap_controller_chk.sv
// ==========================================================
// port checker for the tap controller
module jtag_tap_controller_chk #(
   parameter NIN = 4,
   parameter NOUT = 4,
   parameter SW = 8
) (
   input wire mclk_in,
   input wire resetn_in,
   input wire ce_in,
   input wire tck_in,
   input wire tms_in,
   input wire tdi_in,
   input wire trst_n_in,
   input wire tdo_out,
   input wire tdo_oe_out,
   input wire [NIN-1:0] pad_in,
   input wire [NIN-1:0] core_in_out,
   input wire [NOUT-1:0] core_out_in,
   input wire [NOUT-1:0] pad_out,
   input wire test_mode_out,
   input wire [SW-1:0] stream_data_out,
   input wire stream_valid_out,
   input wire stream_ready_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tck_q;
   logic [2:0] hi_cnt;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   // ==========================================================
   // count test clock rises seen with tms high, saturating at five
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tck_q <= 1'b0;
         hi_cnt <= 3'h0;
      end else begin
         tck_q <= tck_in;
         if (!trst_n_in)
            hi_cnt <= 3'h0;
         else if (tck_in && !tck_q)
            hi_cnt <= tms_in ? hi_cnt + {2'h0, hi_cnt != 3'h5} : 3'h0;
      end
   end
   // ==========================================================
   // assertions
   a_tms_reset: assert property (hi_cnt == 3'h5 |-> ##8 !test_mode_out && !tdo_oe_out)
      else $error("five tms high clocks did not reach reset");
   a_tdo_on_fall: assert property (disable iff (!resetn_in || !trst_n_in)
      $changed(tdo_out) |-> !$past(tck_in, 2))
      else $error("tdo moved outside a test clock low phase");
   a_oe_on_fall: assert property (disable iff (!resetn_in || !trst_n_in)
      $changed(tdo_oe_out) |-> !$past(tck_in, 2))
      else $error("tdo enable moved outside a test clock low phase");
   a_trst_quiet: assert property (!trst_n_in |=> !tdo_oe_out && !tdo_out)
      else $error("test reset did not silence tdo");
   a_latch_update: assert property (disable iff (!resetn_in || !trst_n_in)
      test_mode_out && $past(test_mode_out) && $changed(pad_out) |-> $past(tck_in, 2))
      else $error("boundary latch changed off an update edge");
   a_core_through: assert property (!test_mode_out && !$past(test_mode_out)
      && $past(resetn_in) |-> pad_out == $past(core_out_in))
      else $error("pads do not follow core outside test mode");
   a_stream_hold: assert property (stream_valid_out && !stream_ready_in
      |=> stream_valid_out && $stable(stream_data_out))
      else $error("stream word dropped while stalled");
   a_mode_rise: assert property ($rose(test_mode_out) |-> $past(tck_in, 2))
      else $error("instruction changed off a test clock rise");
   c_extest: cover property ($rose(test_mode_out));
   c_pop: cover property (stream_valid_out && stream_ready_in);
   c_reset: cover property (hi_cnt == 3'h5);
endmodule // jtag_tap_controller_chk

//--- tb/jtag_probe.sv
// ==========================================================
// debug probe: drives the test pins, samples tdo
module jtag_probe (
   input wire logic mclk,
   input wire logic tdo,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins idle with the test clock standing low
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b1;
   end
   // one 80 ns test clock: pins set in the low phase, tdo taken before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (5) @(posedge mclk);
      #1 q = tdo;
      tck = 1'b1;
      repeat (5) @(posedge mclk);
      #1 tck = 1'b0;
   endtask
   // scan from idle back to idle, lsb first, optional pause after bit p
   task automatic scan(input logic ir, input int n, input logic [7:0] din, input int p,
                       output logic [7:0] dout);
      logic q;
      dout = 8'h00;
      step(1'b1, 1'b0, q);
      if (ir)
         step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || i == p, din[i], q);
         dout[i] = q;
         if (i == p) begin
            step(1'b0, 1'b0, q);
            step(1'b0, 1'b0, q);
            step(1'b1, 1'b0, q);
            step(1'b0, 1'b0, q);
         end
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
   // asynchronous test reset pulse
   task automatic trst_pulse();
      trst_n = 1'b0;
      repeat (3) @(posedge mclk);
      #1 trst_n = 1'b1;
   endtask
endmodule // jtag_probe

//--- tb/test_jtag_tap_controller.sv
`include "jtag_tap_consts.vh"

// ==========================================================
// self-checking bench for the tap controller
module test_jtag_tap_controller;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [3:0] pad_in = 4'h0;
   logic [3:0] core_out_in = 4'h0;
   logic stream_ready_in = 1'b0;
   wire tck_in, tms_in, tdi_in, trst_n_in, tdo_out, tdo_oe_out, test_mode_out;
   wire stream_valid_out;
   wire [3:0] core_in_out, pad_out;
   wire [7:0] stream_data_out;
   int mismatches = 0;
   int n_tests = 0;
   integer seed = 32'h7a0849b7;
   logic [31:0] r;
   logic [7:0] w [0:10];
   logic [7:0] o;
   logic q;
   always #4 mclk_in = ~mclk_in;
   jtag_tap_controller jtag_tap_controller_i (.mclk_in, .resetn_in, .ce_in(1'b1), .tck_in,
      .tms_in, .tdi_in, .trst_n_in, .tdo_out, .tdo_oe_out, .pad_in, .core_in_out,
      .core_out_in, .pad_out, .test_mode_out, .stream_data_out, .stream_valid_out,
      .stream_ready_in);
   jtag_probe jtag_probe_i (.mclk(mclk_in), .tdo(tdo_out), .tck(tck_in), .tms(tms_in),
      .tdi(tdi_in), .trst_n(trst_n_in));
   // ==========================================================
   // helpers
   function automatic logic [7:0] byp(input logic [7:0] d);
      return {d[6:0], 1'b0};
   endfunction
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tms5();
      repeat (5) jtag_probe_i.step(1'b1, 1'b0, q);
   endtask
   task automatic bypchk(input string t);
      #1 jtag_probe_i.step(1'b0, 1'b0, q);
      r = $random(seed);
      jtag_probe_i.scan(1'b0, 8, r[7:0], -1, o);
      chk(o === byp(r[7:0]), t);
      $display("test done: %s", t);
   endtask
   task automatic pop(input logic [7:0] e);
      int i;
      for (i = 0; i < 50; i++) begin
         @(negedge mclk_in);
         if (stream_valid_out === 1'b1)
            break;
      end
      chk(i < 50 && stream_data_out === e, "stream word");
      if (i == 50)
         results();
      @(posedge mclk_in);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge mclk_in);
      #1 resetn_in = 1'b1;
      repeat (6) @(posedge mclk_in);
      bypchk("bypass after reset");
      r = $random(seed);
      pad_in = r[3:0];
      core_out_in = r[7:4];
      jtag_probe_i.scan(1'b1, 4, {4'h0, `IR_SAMPLE}, 1, o);
      chk(o[3:0] === `IR_CAPTURE, "ir capture");
      jtag_probe_i.scan(1'b0, 8, 8'h00, 3, o);
      chk(o === {core_out_in, pad_in}, "sample capture");
      $display("test done: sample");
      jtag_probe_i.scan(1'b1, 4, {4'h0, `IR_EXTEST}, -1, o);
      for (int k = 0; k < 2; k++) begin
         r = $random(seed);
         jtag_probe_i.scan(1'b0, 8, r[7:0], 4, o);
         repeat (4) @(posedge mclk_in);
         #1;
         chk(pad_out === r[7:4] && core_in_out === r[3:0], "extest latch");
         chk(test_mode_out === 1'b1, "extest mode");
      end
      $display("test done: extest");
      jtag_probe_i.step(1'b1, 1'b0, q);
      jtag_probe_i.step(1'b0, 1'b0, q);
      jtag_probe_i.step(1'b0, 1'b0, q);
      tms5();
      repeat (4) @(posedge mclk_in);
      chk(test_mode_out === 1'b0 && pad_out === core_out_in && core_in_out === pad_in,
         "tms reset");
      bypchk("reset by tms");
      jtag_probe_i.scan(1'b1, 4, {4'h0, `IR_EXTEST}, -1, o);
      jtag_probe_i.trst_pulse();
      repeat (4) @(posedge mclk_in);
      chk(test_mode_out === 1'b0, "test reset");
      bypchk("test reset");
      jtag_probe_i.scan(1'b1, 4, {4'h0, `IR_STREAM}, -1, o);
      for (int k = 0; k < 11; k++) begin
         r = $random(seed);
         w[k] = r[7:0];
         jtag_probe_i.scan(1'b0, 8, w[k], -1, o);
         chk(o === {7'h00, k == 10}, "busy flag");
      end
      @(posedge mclk_in);
      #1 stream_ready_in = 1'b1;
      for (int k = 0; k < 10; k++)
         pop(w[k]);
      repeat (4) @(posedge mclk_in);
      chk(stream_valid_out === 1'b0, "stream empty");
      $display("test done: stream");
      results();
   end
endmodule // test_jtag_tap_controller

bind jtag_tap_controller jtag_tap_controller_chk #(.NIN(NIN), .NOUT(NOUT), .SW(SW))
   jtag_tap_controller_chk_i (
   .mclk_in, .resetn_in, .ce_in, .tck_in, .tms_in, .tdi_in, .trst_n_in, .tdo_out,
   .tdo_oe_out, .pad_in, .core_in_out, .core_out_in, .pad_out, .test_mode_out,
   .stream_data_out, .stream_valid_out, .stream_ready_in);
